//--- src/vectored_interrupt_controller.sv
`timescale 1ns/10ps
module vectored_interrupt_controller
  import vic_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Wishbone classic slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  // Interrupt sources
  input  wire logic [3:0]  porta_pins,
  input  wire logic [2:0]  portf_pins,
  input  wire logic [7:0]  portb_pins,
  input  wire logic [5:0]  periph_evt,
  // Core side
  input  wire logic        instr_end,
  input  wire logic        trap_exec,
  input  wire logic        irq_return_instr,
  input  wire logic        mask_set_exec,
  input  wire logic        mask_clear_exec,
  input  wire logic        wfi_exec,
  input  wire logic        halt_exec,
  input  wire logic        active_halt_sel,
  input  wire logic [7:0]  vec_rdata,
  output logic             stack_push,
  output logic             stack_pop,
  output logic      [2:0]  stack_sel,
  output logic             vec_rd,
  output logic      [15:0] vec_addr,
  output logic             pc_load,
  output logic      [15:0] pc_value,
  output logic             core_stopped,
  output logic             global_mask,
  output logic      [3:0]  svc_src
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic        condition_code_reg;
  logic [7:0]  sens_reg;
  logic [14:0] pin_en_reg;
  logic [5:0]  per_en_reg;
  logic [5:0]  per_flag_reg;
  logic [5:0]  per_armed_reg;
  logic [3:0]  grp_prev_reg;
  logic [3:0]  ext_latch_reg;
  logic        trap_pend_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  seq_state_t  seq_reg;
  pwr_state_t  pwr_reg;
  logic [2:0]  step_reg;
  logic [3:0]  src_reg;
  logic [15:0] vec_base_reg;
  logic [7:0]  pc_hi_reg;
  logic [7:0]  pc_lo_reg;
  logic [12:0] stab_cnt_reg;

  logic        wb_req;
  logic        wr_stb;
  logic        rd_stb;
  logic [3:0]  grp_comb;
  logic [3:0]  grp_on;
  logic [3:0]  ext_req;
  logic [NUM_SRC-1:0] src_req;
  logic [3:0]  best_src;
  logic        best_vld;
  logic        take;
  logic        enter_svc;
  logic        wake_wait;
  logic        wake_halt;
  logic        wake_ahalt;
  logic [5:0]  per_clr;

  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_stb = wb_req && wb_we_i && wb_sel_i[0];
  assign rd_stb = wb_req && !wb_we_i;

  // ---------------------------------------------------------------
  // Wishbone slave: one wait state, unmapped reads return zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= wb_req;
      rdata_reg <= 32'h0000_0000;
      if (rd_stb) begin
        case (wb_adr_i)
          REG_MASK:     rdata_reg <= {31'h0, condition_code_reg};
          REG_SENS:     rdata_reg <= {24'h0, sens_reg};
          REG_PIN_EN:   rdata_reg <= {17'h0, pin_en_reg};
          REG_PER_EN:   rdata_reg <= {26'h0, per_en_reg};
          REG_PER_FLAG: rdata_reg <= {26'h0, per_flag_reg};
          REG_STATUS:   rdata_reg <= {16'h0, 4'(pwr_reg), 1'b0, 3'(seq_reg),
                                      src_reg, ext_latch_reg};
          default:      rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sens_reg   <= SENS_RESET;
      pin_en_reg <= PIN_EN_RESET;
      per_en_reg <= PER_EN_RESET;
    end else if (wr_stb) begin
      case (wb_adr_i)
        REG_SENS:   sens_reg   <= wb_dat_i[7:0];
        REG_PIN_EN: begin
          pin_en_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) begin
            pin_en_reg[14:8] <= wb_dat_i[14:8];
          end
        end
        REG_PER_EN: per_en_reg <= wb_dat_i[5:0];
        default:    ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Global mask
  // ---------------------------------------------------------------
  // Hardware entry wins over software so a handler always starts masked
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      condition_code_reg <= 1'b1;
    end else if (seq_reg == SEQ_PUSH && step_reg == FRAME_LEN - 3'h1) begin
      condition_code_reg <= 1'b1;
    end else if (seq_reg == SEQ_POP && step_reg == FRAME_LEN - 3'h1) begin
      condition_code_reg <= 1'b0;
    end else if (pwr_reg == PWR_RUN && seq_reg == SEQ_IDLE && (wfi_exec || halt_exec)) begin
      condition_code_reg <= 1'b0;
    end else if (mask_set_exec) begin
      condition_code_reg <= 1'b1;
    end else if (mask_clear_exec) begin
      condition_code_reg <= 1'b0;
    end else if (wr_stb && wb_adr_i == REG_MASK) begin
      condition_code_reg <= wb_dat_i[MASK_BIT];
    end
  end

  assign global_mask = condition_code_reg;

  // ---------------------------------------------------------------
  // External pin groups
  // ---------------------------------------------------------------
  // Disabled pins are forced high so they never hold the NAND output
  always_comb begin
    grp_comb[0] = ~&(porta_pins      | ~pin_en_reg[PIN_F_LSB-1:PIN_A_LSB]);
    grp_comb[1] = ~&(portf_pins      | ~pin_en_reg[PIN_BL_LSB-1:PIN_F_LSB]);
    grp_comb[2] = ~&(portb_pins[3:0] | ~pin_en_reg[PIN_BH_LSB-1:PIN_BL_LSB]);
    grp_comb[3] = ~&(portb_pins[7:4] | ~pin_en_reg[14:PIN_BH_LSB]);
    grp_on[0]   = |pin_en_reg[PIN_F_LSB-1:PIN_A_LSB];
    grp_on[1]   = |pin_en_reg[PIN_BL_LSB-1:PIN_F_LSB];
    grp_on[2]   = |pin_en_reg[PIN_BH_LSB-1:PIN_BL_LSB];
    grp_on[3]   = |pin_en_reg[14:PIN_BH_LSB];
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      grp_prev_reg <= 4'h0;
    end else begin
      grp_prev_reg <= grp_comb;
    end
  end

  // Edge latches; a new edge in the entry cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ext_latch_reg <= 4'h0;
    end else begin
      for (int g = 0; g < 4; g++) begin
        logic rise;
        logic fall;
        logic hit;
        rise = grp_comb[g] && !grp_prev_reg[g];
        fall = !grp_comb[g] && grp_prev_reg[g];
        case (sens_reg[2*g +: 2])
          SENS_RISE: hit = rise;
          SENS_FALL: hit = fall;
          SENS_BOTH: hit = rise || fall;
          default:   hit = 1'b0;
        endcase
        if (hit) begin
          ext_latch_reg[g] <= 1'b1;
        end else if (enter_svc && src_reg == SRC_EXT_FIRST + 4'(g)) begin
          ext_latch_reg[g] <= 1'b0;
        end
      end
    end
  end

  // A group with no enabled pin never requests; its NAND output idles low
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      if (sens_reg[2*g +: 2] == SENS_LOW_LEVEL) begin
        ext_req[g] = grp_on[g] && !grp_comb[g];
      end else begin
        ext_req[g] = grp_on[g] && ext_latch_reg[g];
      end
    end
  end

  // ---------------------------------------------------------------
  // Peripheral flags
  // ---------------------------------------------------------------
  // Reading the flag register arms the set flags; a later access to the
  // associated register clears only those, so newer events are kept
  always_comb begin
    per_clr = 6'h00;
    if (wr_stb && wb_adr_i == REG_PER_FLAG) begin
      per_clr = ~wb_dat_i[5:0];
    end else if (wb_req && wb_adr_i == REG_PER_ASSOC) begin
      per_clr = per_armed_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      per_flag_reg  <= 6'h00;
      per_armed_reg <= 6'h00;
    end else begin
      per_flag_reg <= periph_evt | (per_flag_reg & ~per_clr);
      if (wb_req && wb_adr_i == REG_PER_FLAG) begin
        per_armed_reg <= per_flag_reg;
      end else if (wb_req && wb_adr_i == REG_PER_ASSOC) begin
        per_armed_reg <= 6'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Request vector and priority
  // ---------------------------------------------------------------
  always_comb begin
    src_req = '0;
    for (int p = 0; p < 6; p++) begin
      src_req[PER_SRC[p]] = per_flag_reg[p] && per_en_reg[p];
    end
    src_req[SRC_EXT_LAST:SRC_EXT_FIRST] = ext_req;
  end

  always_comb begin
    best_src = 4'h0;
    best_vld = 1'b0;
    for (int s = NUM_SRC - 1; s >= 1; s--) begin
      if (src_req[s]) begin
        best_src = 4'(s);
        best_vld = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      trap_pend_reg <= 1'b0;
    end else if (trap_exec) begin
      trap_pend_reg <= 1'b1;
    end else if (enter_svc && src_reg == SRC_TRAP) begin
      trap_pend_reg <= 1'b0;
    end
  end

  assign take = instr_end && seq_reg == SEQ_IDLE && pwr_reg == PWR_RUN &&
                (trap_pend_reg || (best_vld && !condition_code_reg));
  assign enter_svc = seq_reg == SEQ_LOAD;

  // ---------------------------------------------------------------
  // Power modes and wake-up
  // ---------------------------------------------------------------
  assign wake_wait  = best_vld;
  assign wake_halt  = |ext_req;
  assign wake_ahalt = |ext_req || src_req[SRC_CLOCK];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pwr_reg      <= PWR_RUN;
      stab_cnt_reg <= 13'h0000;
    end else begin
      case (pwr_reg)
        PWR_RUN: begin
          if (seq_reg == SEQ_IDLE && !take && wfi_exec) begin
            pwr_reg <= PWR_WAIT;
          end else if (seq_reg == SEQ_IDLE && !take && halt_exec) begin
            pwr_reg <= active_halt_sel ? PWR_ACTIVE_HALT : PWR_HALT;
          end
        end
        PWR_WAIT: begin
          if (wake_wait) begin
            pwr_reg <= PWR_RUN;
          end
        end
        PWR_HALT: begin
          if (wake_halt) begin
            pwr_reg      <= PWR_STAB;
            stab_cnt_reg <= 13'h0000;
          end
        end
        PWR_ACTIVE_HALT: begin
          if (wake_ahalt) begin
            pwr_reg      <= PWR_STAB;
            stab_cnt_reg <= 13'h0000;
          end
        end
        PWR_STAB: begin
          if (stab_cnt_reg == STAB_LAST) begin
            pwr_reg <= PWR_RUN;
          end else begin
            stab_cnt_reg <= stab_cnt_reg + 13'h0001;
          end
        end
        default: pwr_reg <= PWR_RUN;
      endcase
    end
  end

  assign core_stopped = pwr_reg != PWR_RUN;

  // ---------------------------------------------------------------
  // Entry and return sequencer
  // ---------------------------------------------------------------
  // Reset fetches its vector first, so it outranks every other source
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      seq_reg      <= SEQ_FETCH_HI;
      step_reg     <= 3'h0;
      src_reg      <= SRC_RESET;
      vec_base_reg <= VEC_RESET;
      pc_hi_reg    <= 8'h00;
      pc_lo_reg    <= 8'h00;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          step_reg <= 3'h0;
          if (take) begin
            seq_reg <= SEQ_PUSH;
            if (trap_pend_reg) begin
              src_reg      <= SRC_TRAP;
              vec_base_reg <= VEC_TRAP;
            end else begin
              src_reg      <= best_src;
              vec_base_reg <= VEC_SRC0 - {11'h000, best_src, 1'b0};
            end
          end else if (irq_return_instr && pwr_reg == PWR_RUN) begin
            seq_reg <= SEQ_POP;
          end
        end
        SEQ_PUSH, SEQ_POP: begin
          step_reg <= step_reg + 3'h1;
          if (step_reg == FRAME_LEN - 3'h1) begin
            seq_reg <= (seq_reg == SEQ_PUSH) ? SEQ_FETCH_HI : SEQ_IDLE;
          end
        end
        SEQ_FETCH_HI: begin
          pc_hi_reg <= vec_rdata;
          seq_reg   <= SEQ_FETCH_LO;
        end
        SEQ_FETCH_LO: begin
          pc_lo_reg <= vec_rdata;
          seq_reg   <= SEQ_LOAD;
        end
        SEQ_LOAD: seq_reg <= SEQ_IDLE;
        default: seq_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Frame pushed PCL first, CC last; popped in the opposite order
  always_comb begin
    stack_push = seq_reg == SEQ_PUSH;
    stack_pop  = seq_reg == SEQ_POP;
    if (seq_reg == SEQ_POP) begin
      stack_sel = STK_CC - step_reg;
    end else if (seq_reg == SEQ_PUSH) begin
      stack_sel = STK_PCL + step_reg;
    end else begin
      stack_sel = STK_PCL;
    end
    vec_rd   = seq_reg == SEQ_FETCH_HI || seq_reg == SEQ_FETCH_LO;
    vec_addr = (seq_reg == SEQ_FETCH_LO) ? (vec_base_reg | 16'h0001) : vec_base_reg;
    pc_load  = seq_reg == SEQ_LOAD;
  end

  assign pc_value = {pc_hi_reg, pc_lo_reg};
  assign svc_src  = src_reg;

endmodule

//--- src/vic_pkg.sv
package vic_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the Wishbone slave)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_MASK     = 8'h00;
  localparam logic [7:0] REG_SENS     = 8'h04;
  localparam logic [7:0] REG_PIN_EN   = 8'h08;
  localparam logic [7:0] REG_PER_EN   = 8'h0c;
  localparam logic [7:0] REG_PER_FLAG = 8'h10;
  localparam logic [7:0] REG_PER_ASSOC = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;

  localparam int          MASK_BIT      = 0;
  localparam logic [7:0]  SENS_RESET    = 8'h00;
  localparam logic [14:0] PIN_EN_RESET  = 15'h0000;
  localparam logic [5:0]  PER_EN_RESET  = 6'h00;
  localparam int          PIN_A_LSB     = 0;
  localparam int          PIN_F_LSB     = 4;
  localparam int          PIN_BL_LSB    = 7;
  localparam int          PIN_BH_LSB    = 11;

  // ---------------------------------------------------------------
  // Sources, vectors and sensitivity
  // ---------------------------------------------------------------
  localparam int          NUM_SRC       = 14;
  localparam logic [3:0]  SRC_CLOCK     = 4'h1;
  localparam logic [3:0]  SRC_EXT_FIRST = 4'h2;
  localparam logic [3:0]  SRC_EXT_LAST  = 4'h5;
  localparam logic [3:0]  SRC_TRAP      = 4'hf;
  localparam logic [3:0]  SRC_RESET     = 4'he;
  localparam logic [15:0] VEC_RESET     = 16'hfffe;
  localparam logic [15:0] VEC_TRAP      = 16'hfffc;
  localparam logic [15:0] VEC_SRC0      = 16'hfffa;

  // Peripheral flag index to source number
  localparam logic [3:0] PER_SRC [6] = '{4'h1, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};

  localparam logic [1:0] SENS_LOW_LEVEL = 2'h0;
  localparam logic [1:0] SENS_RISE      = 2'h1;
  localparam logic [1:0] SENS_FALL      = 2'h2;
  localparam logic [1:0] SENS_BOTH      = 2'h3;

  // ---------------------------------------------------------------
  // Timing and stack frame
  // ---------------------------------------------------------------
  localparam int          STAB_CYCLES   = 4096;
  localparam logic [12:0] STAB_LAST     = 13'(STAB_CYCLES - 1);
  localparam logic [2:0]  FRAME_LEN     = 3'h5;
  localparam logic [2:0]  STK_PCL       = 3'h0;
  localparam logic [2:0]  STK_PCH       = 3'h1;
  localparam logic [2:0]  STK_X         = 3'h2;
  localparam logic [2:0]  STK_A         = 3'h3;
  localparam logic [2:0]  STK_CC        = 3'h4;

  typedef enum logic [2:0] {SEQ_IDLE, SEQ_PUSH, SEQ_FETCH_HI, SEQ_FETCH_LO,
                            SEQ_LOAD, SEQ_POP} seq_state_t;
  typedef enum logic [2:0] {PWR_RUN, PWR_WAIT, PWR_HALT, PWR_ACTIVE_HALT,
                            PWR_STAB} pwr_state_t;

endpackage

//--- testbench/core_model.sv
`timescale 1ns/10ps
// ----
// CPU core stand-in
// ----
module core_model
  import vic_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        pc_load,
  input  wire logic [15:0] vec_addr,
  input  wire logic [3:0]  svc_src,
  output logic             instr_end,
  output logic             irq_return_instr,
  output logic      [7:0]  vec_rdata
);
  logic [5:0] run_reg;
  // Odd byte inverted, so a swapped fetch order shows in the loaded PC
  assign vec_rdata = vec_addr[0] ? ~vec_addr[7:0] : vec_addr[7:0];
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      instr_end <= 1'b0;
      irq_return_instr <= 1'b0;
      run_reg <= 6'h00;
    end else begin
      instr_end <= ~instr_end;
      // Handler runs 40 cycles, then returns; the reset entry never returns
      irq_return_instr <= (run_reg == 6'h01) && (svc_src != SRC_RESET);
      if (pc_load) begin
        run_reg <= 6'h28;
      end else if (run_reg != 6'h00) begin
        run_reg <= run_reg - 6'h01;
      end
    end
  end
endmodule

//--- testbench/vic_asserts.sv
`timescale 1ns/10ps
// ----
// Port checker
// ----
module vic_asserts
  import vic_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        instr_end,
  input wire logic [7:0]  vec_rdata,
  input wire logic        stack_push,
  input wire logic        stack_pop,
  input wire logic [2:0]  stack_sel,
  input wire logic        vec_rd,
  input wire logic [15:0] vec_addr,
  input wire logic        pc_load,
  input wire logic [15:0] pc_value,
  input wire logic        core_stopped,
  input wire logic        global_mask
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  property p_mask_rst;
    $fell(sys_rst) |-> global_mask;
  endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("mask clear after reset");
  property p_push;
    $rose(stack_push) |-> stack_sel == STK_PCL ##1 stack_push && stack_sel == STK_PCH
      ##1 stack_push && stack_sel == STK_X ##1 stack_push && stack_sel == STK_A
      ##1 stack_push && stack_sel == STK_CC ##1 !stack_push && global_mask && vec_rd;
  endproperty
  a_push: assert property (p_push) else $error("bad entry frame");
  property p_entry_cause;
    $rose(stack_push) |-> $past(instr_end);
  endproperty
  a_entry_cause: assert property (p_entry_cause) else $error("entry off boundary");
  property p_vec_pair;
    $rose(vec_rd) |-> !vec_addr[0] && vec_addr[15:5] == 11'h7ff
      ##1 vec_rd && vec_addr == $past(vec_addr) + 16'h0001 ##1 pc_load && !vec_rd;
  endproperty
  a_vec_pair: assert property (p_vec_pair) else $error("bad vector fetch");
  property p_pc_value;
    pc_load |-> pc_value == {$past(vec_rdata, 2), $past(vec_rdata)};
  endproperty
  a_pc_value: assert property (p_pc_value) else $error("bad byte order");
  property p_pop;
    $rose(stack_pop) |-> stack_sel == STK_CC ##1 stack_sel == STK_A ##1 stack_sel == STK_X
      ##1 stack_sel == STK_PCH ##1 stack_sel == STK_PCL ##1 !global_mask;
  endproperty
  a_pop: assert property (p_pop) else $error("bad return frame");
  property p_sleep;
    $rose(core_stopped) |-> !global_mask;
  endproperty
  a_sleep: assert property (p_sleep) else $error("mask set in sleep");
endmodule

bind vectored_interrupt_controller vic_asserts i_vic_asserts (.clk_sys, .sys_rst, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .instr_end, .vec_rdata, .stack_push, .stack_pop, .stack_sel, .vec_rd, .vec_addr, .pc_load,
  .pc_value, .core_stopped, .global_mask);

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb;
  import vic_pkg::*;
  logic        clk_sys, sys_rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, instr_end, trap_exec;
  logic        irq_return_instr, mask_set_exec, mask_clear_exec, wfi_exec, halt_exec, active_halt_sel;
  logic        stack_push, stack_pop, vec_rd, pc_load, core_stopped, global_mask;
  logic [7:0]  wb_adr_i, portb_pins, vec_rdata;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [3:0]  wb_sel_i, porta_pins, svc_src;
  logic [2:0]  portf_pins, stack_sel;
  logic [5:0]  periph_evt;
  logic [15:0] vec_addr, pc_value;
  int          mismatches, n_checks, n;

  vectored_interrupt_controller i_vectored_interrupt_controller (.clk_sys, .sys_rst, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .porta_pins, .portf_pins, .portb_pins,
    .periph_evt, .instr_end, .trap_exec, .irq_return_instr, .mask_set_exec, .mask_clear_exec, .wfi_exec,
    .halt_exec, .active_halt_sel, .vec_rdata, .stack_push, .stack_pop, .stack_sel, .vec_rd, .vec_addr,
    .pc_load, .pc_value, .core_stopped, .global_mask, .svc_src);
  core_model i_core_model (.clk_sys, .sys_rst, .pc_load, .vec_addr, .svc_src, .instr_end,
    .irq_return_instr, .vec_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----
  // Shared tasks
  // ----
  task wrap_up;
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function logic sig(input int s);
    case (s)
      0: sig = pc_load;
      1: sig = stack_pop;
      2: sig = ~stack_pop;
      3: sig = ~core_stopped;
      default: sig = wb_ack_o;
    endcase
  endfunction
  // Counts edges until the chosen flag is sampled high; a spent bound ends the run
  task wait_for(input int s, input int lim);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sig(s) !== 1'b1 && n < lim);
    if (sig(s) !== 1'b1) begin
      chk("wait bound", 32'(s), 32'hffff);
      wrap_up();
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wait_for(4, 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task evt(input logic [5:0] m);
    @(posedge clk_sys);
    periph_evt <= m;
    @(posedge clk_sys);
    periph_evt <= 6'h00;
  endtask
  task mset(input logic s);
    @(posedge clk_sys);
    mask_set_exec <= s;
    mask_clear_exec <= ~s;
    @(posedge clk_sys);
    mask_set_exec <= 1'b0;
    mask_clear_exec <= 1'b0;
  endtask
  task wait_pc(input logic [15:0] v);
    wait_for(0, 6000);
    chk("pc_value", pc_value, {16'h0, v[7:0], ~(v[7:0] + 8'h01)});
  endtask
  // Serve one entry, clear the flags whose bits are zero in clr, then follow the return
  task svc(input logic [3:0] src, input logic [31:0] clr);
    wait_pc(src == SRC_TRAP ? VEC_TRAP : VEC_SRC0 - 16'(2 * src));
    chk("mask in handler", 32'(global_mask), 32'h1);
    portf_pins <= 3'h0;
    wb(1'b1, REG_PER_FLAG, clr);
    chk("svc_src", 32'(svc_src), 32'(src));
    wait_for(1, 100);
    wait_for(2, 10);
    chk("mask after return", 32'(global_mask), 32'h0);
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    {wb_we_i, wb_cyc_i, wb_stb_i, trap_exec, mask_set_exec, mask_clear_exec} = 6'h00;
    {wfi_exec, halt_exec, active_halt_sel} = 3'h0;
    {wb_adr_i, wb_dat_i, wb_sel_i, periph_evt} = {8'h00, 32'h0, 4'hf, 6'h00};
    {porta_pins, portf_pins, portb_pins} = {4'hf, 3'h0, 8'hff};
    mismatches = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wait_pc(VEC_RESET);
    chk("mask after reset", 32'(global_mask), 32'h1);
    wb(1'b0, 8'hfc, 32'h0);
    chk("unmapped read", q, 32'h0);
    wb(1'b1, REG_PER_EN, 32'h3f);
    evt(6'h02);
    repeat (30) @(posedge clk_sys);
    chk("svc_src masked", 32'(svc_src), 32'(SRC_RESET));
    wb(1'b0, REG_PER_FLAG, 32'h0);
    chk("pending flag", 32'(q[1]), 32'h1);
    mset(1'b0);
    svc(4'h7, 32'h3d);
    // Trap under mask, then two sources waiting together
    wb(1'b1, REG_MASK, 32'h1);
    evt(6'h09);
    @(posedge clk_sys);
    trap_exec <= 1'b1;
    @(posedge clk_sys);
    trap_exec <= 1'b0;
    svc(SRC_TRAP, 32'h3f);
    svc(4'h1, 32'h3e);
    svc(4'h9, 32'h36);
    // Flag read then associated access discards a request not yet enabled
    wb(1'b1, REG_PER_EN, 32'h3b);
    evt(6'h04);
    wb(1'b0, REG_PER_FLAG, 32'h0);
    wb(1'b0, REG_PER_ASSOC, 32'h0);
    wb(1'b0, REG_PER_FLAG, 32'h0);
    chk("flag after sequence", 32'(q[2]), 32'h0);
    wb(1'b1, REG_PER_EN, 32'h3f);
    repeat (20) @(posedge clk_sys);
    chk("svc_src discarded", 32'(svc_src), 32'h9);
    // Pin groups: A0/A1 rising, F0 low level, B0 rising
    wb(1'b1, REG_SENS, 32'h11);
    wb(1'b1, REG_MASK, 32'h1);
    wb(1'b1, REG_PIN_EN, 32'h0093);
    @(posedge clk_sys);
    porta_pins <= 4'hd;
    repeat (3) @(posedge clk_sys);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("edge latch", 32'(q[0]), 32'h1);
    mset(1'b0);
    svc(4'h2, 32'h3f);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("edge latch served", 32'(q[0]), 32'h0);
    porta_pins <= 4'hc;
    repeat (2) @(posedge clk_sys);
    porta_pins <= 4'hd;
    repeat (20) @(posedge clk_sys);
    chk("svc_src held low", 32'(svc_src), 32'h2);
    mset(1'b1);
    portf_pins <= 3'h1;
    repeat (3) @(posedge clk_sys);
    portf_pins <= 3'h0;
    mset(1'b0);
    repeat (20) @(posedge clk_sys);
    chk("svc_src level gone", 32'(svc_src), 32'h2);
    portf_pins <= 3'h1;
    svc(4'h3, 32'h3f);
    // Full halt: clock source ignored, pin edge wakes after stabilisation
    @(posedge clk_sys);
    halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    evt(6'h01);
    repeat (30) @(posedge clk_sys);
    chk("stopped in halt", 32'(core_stopped), 32'h1);
    wb(1'b1, REG_PER_FLAG, 32'h3e);
    portb_pins <= 8'hfe;
    wait_for(3, 5000);
    chk("stabilisation", 32'(n >= 4096 && n <= 4104), 32'h1);
    svc(4'h4, 32'h3f);
    @(posedge clk_sys);
    wfi_exec <= 1'b1;
    @(posedge clk_sys);
    wfi_exec <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("stopped in wait", 32'(core_stopped), 32'h1);
    evt(6'h08);
    svc(4'h9, 32'h37);
    // Active halt: serial source ignored, clock source wakes after stabilisation
    @(posedge clk_sys);
    active_halt_sel <= 1'b1;
    halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    evt(6'h02);
    repeat (30) @(posedge clk_sys);
    chk("stopped in active halt", 32'(core_stopped), 32'h1);
    wb(1'b1, REG_PER_FLAG, 32'h3d);
    evt(6'h01);
    wait_for(3, 5000);
    chk("active halt stabilisation", 32'(n >= 4096 && n <= 4104), 32'h1);
    svc(4'h1, 32'h3e);
    wrap_up();
  end
endmodule
